/* core/qr_valley_pkg.sv */
// Purpose: Shared types and constants for the valley select core
// Assumes: 10 MHz system clock
// Notes:   All timing counts derive from times in their own units
package qr_valley_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ       = 10_000_000;
    // Soft-start total time and step count
    localparam int unsigned SS_TIME_MS   = 12;
    localparam int unsigned SS_STEPS     = 4;
    localparam int unsigned SS_STEP_CYC  =
        (SS_TIME_MS * (CLK_HZ / 1000)) / SS_STEPS;
    // Feedback evaluation period
    localparam int unsigned UPD_TIME_MS  = 48;
    localparam int unsigned UPD_CYC      = UPD_TIME_MS * (CLK_HZ / 1000);

    // Valley and crossing counter limits
    localparam logic [2:0] VAL_MIN  = 3'h1;
    localparam logic [2:0] VAL_MAX  = 3'h7;
    localparam logic [2:0] ZC_MAX   = 3'h7;
    localparam logic [2:0] ZC_ZERO  = 3'h0;
    // Soft-start step index limits (step 3 is the final 1 V level)
    localparam logic [1:0] SS_FIRST = 2'h0;
    localparam logic [1:0] SS_LAST  = 2'h3;

    // Operating phase
    typedef enum logic [1:0] {
        PH_CHARGE = 2'b00, // Waiting for supply turn-on
        PH_SOFT   = 2'b01, // Soft-start stepping
        PH_RUN    = 2'b10  // Normal switching
    } phase_t;

    // Raw comparator flags for the feedback voltage
    typedef struct packed {
        logic fb_low;   // Above low threshold, low-line set
        logic fb_high;  // Above high threshold, low-line set
        logic fb_low_hl;  // Above low threshold, high-line set
        logic fb_high_hl; // Above high threshold, high-line set
        logic fb_reset; // Above reset threshold
    } fb_cmp_t;

    // Sticky flags gathered over one period
    typedef struct packed {
        logic low;
        logic high;
        logic rst;
    } fb_seen_t;

endpackage

/* core/sync3.sv */
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_sys
// Notes:   Output changes only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module sync3 (
    input  wire logic clk_sys,  // System clock
    input  wire logic reset,    // Synchronous reset, high
    input  wire logic din,      // Asynchronous input
    output logic      dout      // Filtered output
);
    // Stage chain plus filtered level
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } sync_state_t;

    sync_state_t st_reg;   // Registered state
    sync_state_t st_next;  // Next state

    // Shift and accept when the back two stages agree
    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.q = st_reg.s3;
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.q;
endmodule // sync3
`default_nettype wire

/* core/qr_valley_core.sv */
// Purpose: Start-up, soft-start, valley counter and switch-on decision
// Assumes: Comparator flags are asynchronous and synchronised here
// Notes:   Analog limits are driven as a step index, not a voltage
//
// How it works
// RL1: Supply on stops charging and starts soft-start
// RL2: Soft-start lasts 12 ms in four steps
// RL3: Current limit steps from 0.32 V to 1 V
// RL4: Valley counter picks turn-on zero crossing
// RL5: Feedback judged once per 48 ms period
// RL6: Always below low threshold: count up to 7
// RL7: Above low, never above high: hold value
// RL8: Above high, never reset threshold: count down
// RL9: Above reset threshold forces counter to 1
// RL10: Counter saturates between 1 and 7
// RL11: Counter starts at 1 after start-up
// RL12: Line level selects low and high threshold set
// RL13: Gate may turn on when crossings reach counter
// RL14: Crossing count 0..7, cleared when gate rises
// RL15: Sticky flags pick action, then clear each period
`timescale 1ns/100ps
`default_nettype none
module qr_valley_core #(
    // Timing counts; a bench may shorten them to keep runs brief
    parameter int unsigned STEP_CYC = qr_valley_pkg::SS_STEP_CYC, // Step
    parameter int unsigned UPD_CYC  = qr_valley_pkg::UPD_CYC      // Period
) (
    input  wire logic                 clk_sys,       // System clock 10 MHz
    input  wire logic                 reset,         // Synchronous reset
    input  wire logic                 supply_on,     // Supply above turn-on
    input  wire logic                 line_high,     // High line indication
    input  wire qr_valley_pkg::fb_cmp_t fb_cmp,      // Feedback comparators
    input  wire logic                 zero_crossing, // Crossing detected
    input  wire logic                 ring_done,     // Suppression elapsed
    input  wire logic                 gate_on,       // Gate drive state
    output logic                      charge_en,     // Start-up path enable
    output logic                      switching_en,  // Switching allowed
    output logic                      soft_active,   // Soft-start running
    output logic [1:0]                cs_step,       // Limit step 0..3
    output logic [2:0]                valley_sel,    // Up/down counter
    output logic [2:0]                zc_count,      // Crossing count
    output logic                      turn_on_ok     // Switch-on permitted
);
    // Cycle counts at their needed widths
    localparam logic [15:0] STEP_LAST =
        16'(STEP_CYC - 1);
    localparam logic [18:0] UPD_LAST =
        19'(UPD_CYC - 1);

    // Whole module state
    typedef struct packed {
        qr_valley_pkg::phase_t   phase;
        logic [15:0]             ss_cnt;
        logic [1:0]              step;
        logic [18:0]             upd_cnt;
        qr_valley_pkg::fb_seen_t seen;
        logic [2:0]              valley;
        logic [2:0]              zc;
        logic                    gate_d;
        logic                    zc_d;
    } core_state_t;

    core_state_t st_reg;   // Registered state
    core_state_t st_next;  // Next state

    logic [4:0] cmp_s;     // Synchronised comparator flags
    logic       sup_s;     // Synchronised supply indication
    logic       line_s;    // Synchronised line indication
    logic       zc_s;      // Synchronised crossing pulse level
    logic       lo_hit;    // Selected low comparison
    logic       hi_hit;    // Selected high comparison
    logic       period_end; // Last cycle of an update period

    // One synchroniser per asynchronous flag
    sync3 u_sync_sup  (.clk_sys(clk_sys), .reset(reset),
                       .din(supply_on), .dout(sup_s));
    sync3 u_sync_line (.clk_sys(clk_sys), .reset(reset),
                       .din(line_high), .dout(line_s));
    sync3 u_sync_zc   (.clk_sys(clk_sys), .reset(reset),
                       .din(zero_crossing), .dout(zc_s));
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_cmp
            sync3 u_sync (.clk_sys(clk_sys), .reset(reset),
                          .din(fb_cmp[gi]), .dout(cmp_s[gi]));
        end
    endgenerate

    // Threshold set picked by line level
    always_comb begin
        qr_valley_pkg::fb_cmp_t c;
        c      = qr_valley_pkg::fb_cmp_t'(cmp_s);
        lo_hit = line_s ? c.fb_low_hl  : c.fb_low;  // RL12
        hi_hit = line_s ? c.fb_high_hl : c.fb_high; // RL12
    end

    assign period_end = (st_reg.upd_cnt == UPD_LAST); // RL5

    // Next-state logic for all functions
    always_comb begin
        qr_valley_pkg::fb_cmp_t c;
        c        = qr_valley_pkg::fb_cmp_t'(cmp_s);
        st_next  = st_reg;
        st_next.gate_d = gate_on;
        st_next.zc_d   = zc_s;
        case (st_reg.phase)
            qr_valley_pkg::PH_CHARGE: begin
                // Supply above turn-on ends charging
                if (sup_s) begin
                    st_next.phase  = qr_valley_pkg::PH_SOFT; // RL1
                    st_next.ss_cnt = '0;
                    st_next.step   = qr_valley_pkg::SS_FIRST; // RL3
                    st_next.valley = qr_valley_pkg::VAL_MIN; // RL11
                    st_next.upd_cnt = '0;
                    st_next.seen   = '0;
                end
            end
            qr_valley_pkg::PH_SOFT: begin
                // Equal time steps of the limit
                if (st_reg.ss_cnt == STEP_LAST) begin // RL2
                    st_next.ss_cnt = '0;
                    if (st_reg.step == qr_valley_pkg::SS_LAST) begin
                        st_next.phase = qr_valley_pkg::PH_RUN;
                    end else begin
                        st_next.step = st_reg.step + 2'h1; // RL3
                    end
                end else begin
                    st_next.ss_cnt = st_reg.ss_cnt + 16'h0001;
                end
            end
            qr_valley_pkg::PH_RUN: begin
                // Stays running until reset
            end
            default: st_next.phase = qr_valley_pkg::PH_CHARGE;
        endcase

        // Valley evaluation once switching
        if (st_reg.phase != qr_valley_pkg::PH_CHARGE) begin
            if (period_end) begin
                st_next.upd_cnt = '0;
                st_next.seen    = '0; // RL15
                if (st_reg.seen.rst || c.fb_reset) begin
                    st_next.valley = qr_valley_pkg::VAL_MIN; // RL9
                end else if (st_reg.seen.high || hi_hit) begin
                    if (st_reg.valley != qr_valley_pkg::VAL_MIN) begin
                        st_next.valley = st_reg.valley - 3'h1; // RL8
                    end
                end else if (st_reg.seen.low || lo_hit) begin
                    st_next.valley = st_reg.valley; // RL7
                end else if (st_reg.valley != qr_valley_pkg::VAL_MAX) begin
                    st_next.valley = st_reg.valley + 3'h1; // RL6 RL10
                end
            end else begin
                st_next.upd_cnt   = st_reg.upd_cnt + 19'h00001;
                st_next.seen.low  = st_reg.seen.low  | lo_hit; // RL15
                st_next.seen.high = st_reg.seen.high | hi_hit;
                st_next.seen.rst  = st_reg.seen.rst  | c.fb_reset;
            end
        end

        // Crossing counter, cleared on gate rise
        if (gate_on && !st_reg.gate_d) begin
            st_next.zc = qr_valley_pkg::ZC_ZERO; // RL14
        end else if (!gate_on && zc_s && !st_reg.zc_d &&
                     st_reg.zc != qr_valley_pkg::ZC_MAX) begin
            st_next.zc = st_reg.zc + 3'h1; // RL14
        end
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_reg        <= '0;
            st_reg.phase  <= qr_valley_pkg::PH_CHARGE;
            st_reg.valley <= qr_valley_pkg::VAL_MIN; // RL11
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs from state
    assign charge_en    = (st_reg.phase == qr_valley_pkg::PH_CHARGE); // RL1
    assign switching_en = !charge_en;
    assign soft_active  = (st_reg.phase == qr_valley_pkg::PH_SOFT);
    assign cs_step      = st_reg.step;
    assign valley_sel   = st_reg.valley; // RL4
    assign zc_count     = st_reg.zc;
    // Valley reached and ringing window over
    assign turn_on_ok   = switching_en && ring_done &&
                          (st_reg.zc >= st_reg.valley); // RL13

    // Valley never leaves its range
    valley_range_a: assert property (@(posedge clk_sys) disable iff (reset) // RL10
        valley_sel >= qr_valley_pkg::VAL_MIN)
        else $error("valley counter below one");
    // Reset comparator forces one at period end
    valley_force_a: assert property (@(posedge clk_sys) disable iff (reset) // RL9
        (switching_en && period_end && st_reg.seen.rst) |=> valley_sel == 3'h1)
        else $error("reset threshold did not force one");
    // Quiet period counts up by one
    count_up_a: assert property (@(posedge clk_sys) disable iff (reset) // RL6
        (switching_en && period_end && st_reg.seen == '0 && !lo_hit &&
         !hi_hit && !cmp_s[0] && valley_sel != 3'h7)
        |=> valley_sel == $past(valley_sel) + 3'h1)
        else $error("valley counter did not increment");
    // Hold when only low seen
    hold_low_a: assert property (@(posedge clk_sys) disable iff (reset) // RL7
        (switching_en && period_end && st_reg.seen == 3'b100 && !hi_hit &&
         !cmp_s[0]) |=> $stable(valley_sel))
        else $error("valley counter changed on low only");
    // Value changes only at period end
    period_only_a: assert property (@(posedge clk_sys) disable iff (reset) // RL5
        (switching_en && !period_end) |=> $stable(valley_sel))
        else $error("valley changed mid period");
    // Charging off once switching
    startup_a: assert property (@(posedge clk_sys) disable iff (reset) // RL1
        (charge_en && sup_s) |=> (!charge_en && soft_active && cs_step == 2'h0))
        else $error("start-up did not enter soft-start");
    // Step holds between step edges
    step_hold_a: assert property (@(posedge clk_sys) disable iff (reset) // RL2
        (soft_active && st_reg.ss_cnt != STEP_LAST) |=> $stable(cs_step))
        else $error("soft-start step moved early");
    // Gate rise clears crossing count
    zc_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // RL14
        $rose(gate_on) |=> zc_count == 3'h0)
        else $error("crossing count not cleared");
endmodule // qr_valley_core
`default_nettype wire

/* tb/qr_valley_select_softstart_test.sv */
// Purpose: Self-checking bench for the valley select and soft-start core
// Assumes: 10 MHz clock; package timing constants are overridden with shorter counts
// Notes:   Step and period counts shortened, keeping their 1:16 ratio
`timescale 1ns/100ps
`default_nettype none
module qr_valley_select_softstart_test;
    logic                   clk_sys;       // System clock
    logic                   reset;         // Synchronous reset
    logic                   supply_on;     // Supply above turn-on
    logic                   line_high;     // High line indication
    qr_valley_pkg::fb_cmp_t fb_cmp;        // Feedback comparator flags
    logic                   zero_crossing; // Crossing input
    logic                   ring_done;     // Suppression elapsed
    logic                   gate_on;       // Gate drive state
    logic                   charge_en;     // Start-up path enable
    logic                   switching_en;  // Switching allowed
    logic                   soft_active;   // Soft-start running
    logic [1:0]             cs_step;       // Limit step
    logic [2:0]             valley_sel;    // Up/down counter
    logic [2:0]             zc_count;      // Crossing count
    logic                   turn_on_ok;    // Switch-on permitted
    int                     error_cnt;     // Mismatches seen
    int                     checks;        // Comparisons made

    // Shortened timing; full counts would need millions of cycles
    localparam int unsigned STEP_CYC = 100;  // Cycles per soft-start step
    localparam int unsigned UPD_CYC  = 1600; // Cycles per update period

    // One period: line set, flags pulsed, counter value after the period
    typedef struct packed {
        logic                   lh;
        qr_valley_pkg::fb_cmp_t fb;
        logic [2:0]             exp;
    } row_t;
    // Comparators are nested: above high implies above low
    row_t rows [14] = '{
        {1'h0, 5'h00, 3'h2}, {1'h0, 5'h00, 3'h3},
        {1'h1, 5'h18, 3'h4},
        {1'h0, 5'h00, 3'h5}, {1'h0, 5'h00, 3'h6},
        {1'h0, 5'h00, 3'h7}, {1'h0, 5'h00, 3'h7},
        {1'h0, 5'h10, 3'h7}, {1'h0, 5'h18, 3'h6},
        {1'h1, 5'h04, 3'h6}, {1'h1, 5'h06, 3'h5},
        {1'h0, 5'h19, 3'h1}, {1'h0, 5'h18, 3'h1},
        {1'h0, 5'h00, 3'h2}
    };

    qr_valley_core #(
        .STEP_CYC (STEP_CYC),
        .UPD_CYC  (UPD_CYC)
    ) qr_valley_core_inst (
        .clk_sys       (clk_sys),
        .reset         (reset),
        .supply_on     (supply_on),
        .line_high     (line_high),
        .fb_cmp        (fb_cmp),
        .zero_crossing (zero_crossing),
        .ring_done     (ring_done),
        .gate_on       (gate_on),
        .charge_en     (charge_en),
        .switching_en  (switching_en),
        .soft_active   (soft_active),
        .cs_step       (cs_step),
        .valley_sel    (valley_sel),
        .zc_count      (zc_count),
        .turn_on_ok    (turn_on_ok)
    );

    // Free-running 100 ns clock
    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Single-bit result
    task automatic chk_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    // Counter or step result
    task automatic chk_val(input logic [2:0] got, input logic [2:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    // Wait n edges, then settle to the falling edge for sampling
    task automatic wait_cyc(input int unsigned n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // One crossing pulse, long enough for the input filter
    task automatic pulse_zc();
        @(posedge clk_sys);
        zero_crossing <= 1'h1;
        repeat (6) @(posedge clk_sys);
        zero_crossing <= 1'h0;
        wait_cyc(6);
    endtask

    // Main sequence
    initial begin
        reset = 1'h1;
        supply_on = 1'h0;
        line_high = 1'h0;
        fb_cmp = '0;
        zero_crossing = 1'h0;
        ring_done = 1'h0;
        gate_on = 1'h0;
        error_cnt = 0;
        checks = 0;
        wait_cyc(15);
        chk_flag(charge_en, 1'h1);
        chk_flag(switching_en, 1'h0);
        chk_val(valley_sel, 3'h1);
        @(posedge clk_sys);
        reset <= 1'h0;
        @(posedge clk_sys);
        supply_on <= 1'h1;
        // Bounded wait for soft-start entry
        for (int i = 0; i <= 20; i++) begin
            @(negedge clk_sys);
            if (soft_active === 1'h1) break;
            if (i == 20) begin
                error_cnt++;
                $display("[FAIL] %0t soft-start never entered", $time);
                complete_run();
            end
        end
        chk_flag(charge_en, 1'h0);
        chk_flag(switching_en, 1'h1);
        chk_val({1'h0, cs_step}, 3'h0);
        fork
            // Mid-step samples of the limit step
            begin
                wait_cyc(STEP_CYC / 2);
                for (int i = 0; i < 4; i++) begin
                    chk_val({1'h0, cs_step}, i[2:0]);
                    chk_flag(soft_active, 1'h1);
                    wait_cyc(STEP_CYC);
                end
                chk_flag(soft_active, 1'h0);
                chk_val({1'h0, cs_step}, 3'h3);
            end
            // Short flag burst per period, result read after the period
            begin
                wait_cyc(UPD_CYC / 4);
                foreach (rows[i]) begin
                    @(posedge clk_sys);
                    line_high <= rows[i].lh;
                    fb_cmp <= rows[i].fb;
                    repeat (20) @(posedge clk_sys);
                    fb_cmp <= '0;
                    wait_cyc(UPD_CYC - 22);
                    chk_val(valley_sel, rows[i].exp);
                end
            end
        join
        // Supply drop is ignored once switching; counter is now 2
        @(posedge clk_sys);
        supply_on <= 1'h0;
        ring_done <= 1'h1;
        wait_cyc(8);
        chk_flag(switching_en, 1'h1);
        chk_flag(turn_on_ok, 1'h0);
        for (int n = 1; n <= 9; n++) begin
            pulse_zc();
            chk_val(zc_count, (n > 7) ? 3'h7 : n[2:0]);
            chk_flag(turn_on_ok, (n >= 2) ? 1'h1 : 1'h0);
        end
        @(posedge clk_sys);
        ring_done <= 1'h0;
        wait_cyc(2);
        chk_flag(turn_on_ok, 1'h0);
        // Gate high clears the count and blocks crossings
        @(posedge clk_sys);
        gate_on <= 1'h1;
        wait_cyc(3);
        chk_val(zc_count, 3'h0);
        pulse_zc();
        chk_val(zc_count, 3'h0);
        // Reset in mid-run returns to charging with counter at 1
        @(posedge clk_sys);
        reset <= 1'h1;
        wait_cyc(2);
        chk_val(valley_sel, 3'h1);
        chk_flag(charge_en, 1'h1);
        chk_flag(soft_active, 1'h0);
        chk_val({1'h0, cs_step}, 3'h0);
        complete_run();
    end
endmodule // qr_valley_select_softstart_test
`default_nettype wire
